// file: shared/dcs_pkg.sv
package dcs_pkg;
   // converter word and transfer sizes
   localparam int RESULT_W      = 12;
   localparam int FIFO_DEPTH    = 32;
   localparam int SYNC_STAGES   = 2;
   // conversion time, in picoseconds to keep the printed figure exact
   localparam int CONV_TIME_PS  = 406250;
   localparam int CLK_PERIOD_PS = 20000;
   // least time, so rounded up to whole cycles
   localparam int CONV_CYCLES   = (CONV_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W         = 6;
   localparam logic [CNT_W-1:0] CONV_CNT_LOAD = CNT_W'(CONV_CYCLES);
   localparam logic [CNT_W-1:0] LEN_DUAL      = CNT_W'(RESULT_W);
   localparam logic [CNT_W-1:0] LEN_SINGLE    = CNT_W'(2 * RESULT_W);
   localparam logic [CNT_W-1:0] CNT_ZERO      = 6'h00;
   localparam logic [CNT_W-1:0] CNT_ONE       = 6'h01;

   // one simultaneous result pair, converter a in the upper half
   typedef struct packed {
      logic [RESULT_W-1:0] a;
      logic [RESULT_W-1:0] b;
   } dcs_result_s;

   localparam int PAIR_W = 2 * RESULT_W;
   localparam logic [RESULT_W-1:0] WORD_ZERO = 12'h000;
   localparam dcs_result_s RESULT_ZERO = '{a: 12'h000, b: 12'h000};

   typedef enum logic [1:0] {
      ST_SAMPLE,
      ST_HOLD,
      ST_CONVERT,
      ST_STORE
   } dcs_state_e;
endpackage

// file: design/dcs_fifo.sv
`timescale 1ns/1ps
module dcs_fifo
   import dcs_pkg::*;
#(
   parameter int WIDTH = PAIR_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   // clock and reset
   input  wire logic             clk_sys_in,
   input  wire logic             nrst_in,
   // filling side
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   // draining side
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;

   // extra pointer bit tells full from empty
   wire do_push = in_valid_in && in_ready_out;
   wire do_pop  = out_valid_out && out_ready_in;
   assign in_ready_out  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign out_valid_out = (wr_ptr != rd_ptr);
   assign out_data_out  = mem[rd_ptr[AW-1:0]];

   // storage has no reset, only the pointers do
   always_ff @(posedge clk_sys_in) begin
      if (do_push) begin
         mem[wr_ptr[AW-1:0]] <= in_data_in;
      end
   end

   // pointer update
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= wr_ptr + (AW+1)'(do_push);
         rd_ptr <= rd_ptr + (AW+1)'(do_pop);
      end
   end
endmodule

// file: design/dcs_converter_port.sv
`timescale 1ns/1ps
// Overview of operation
// - rising conversion start moves both holds from sampling to hold together
// - conversion begins on the fourth clock edge after the start edge, one edge after the hold
// - busy high while inputs held, low once conversion completes and the result is stored in the buffer
// - host pulses read to frame a transfer; it aligns serial out and in
// - read strobe ignored unless chip select is low
// - chip select low drives line a, and line b too when output select is high; high releases them
// - serial bits stable at falling clock edge; host samples on falling edge
// - output select high: a results on one line, b on other together
// - channel select pin picks which input channel feeds both converters
// - busy drops right after a rising clock edge
module dcs_converter_port
   import dcs_pkg::*;
(
   // clock and reset
   input  wire logic                clk_sys_in,
   input  wire logic                nrst_in,
   // device pins
   input  wire logic                conversion_start_in,
   input  wire logic                rd_in,
   input  wire logic                cs_n_in,
   input  wire logic                serial_in_in,
   input  wire logic                channel_select_pin_in,
   input  wire logic                output_select_pin_in,
   // sampled analog values, same clock domain
   input  wire logic [RESULT_W-1:0] sample_a0_in,
   input  wire logic [RESULT_W-1:0] sample_a1_in,
   input  wire logic [RESULT_W-1:0] sample_b0_in,
   input  wire logic [RESULT_W-1:0] sample_b1_in,
   // status and serial outputs
   output logic                     busy_out,
   output logic                     serial_out_conv_a_out,
   output logic                     serial_out_conv_a_oe_out,
   output logic                     serial_out_conv_b_out,
   output logic                     serial_out_conv_b_oe_out,
   // word received on the serial input
   output logic [RESULT_W-1:0]      serial_in_word_out,
   output logic                     serial_in_valid_out
);
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   localparam int NPIN = 6;
   // idle level of each pin; chip select rests high so no false drive after reset
   localparam logic [NPIN-1:0] PIN_IDLE = 6'h08;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_s1;
   logic [NPIN-1:0] pin_s2;
   logic            start_prev;
   logic            rd_prev;

   assign pin_raw = {conversion_start_in, rd_in, cs_n_in, serial_in_in,
                     channel_select_pin_in, output_select_pin_in};

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         // two stages per pin; only the second stage feeds logic
         always_ff @(posedge clk_sys_in or negedge nrst_in) begin
            if (!nrst_in) begin
               pin_s1[gi] <= PIN_IDLE[gi];
               pin_s2[gi] <= PIN_IDLE[gi];
            end else begin
               pin_s1[gi] <= pin_raw[gi];
               pin_s2[gi] <= pin_s1[gi];
            end
         end
      end
   endgenerate

   wire start_s = pin_s2[5];
   wire rd_s    = pin_s2[4];
   wire cs_n_s  = pin_s2[3];
   wire sin_s   = pin_s2[2];
   wire csel_s  = pin_s2[1];
   wire osel_s  = pin_s2[0];

   // edge detectors look only at the settled stage
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         start_prev <= 1'b0;
         rd_prev    <= 1'b0;
      end else begin
         start_prev <= start_s;
         rd_prev    <= rd_s;
      end
   end

   wire start_rise = start_s && !start_prev;
   wire rd_rise    = rd_s && !rd_prev;

   ////////////////////////////////////////////////////////////////////////////
   // conversion sequencer
   dcs_state_e       state;
   dcs_state_e       next_state;
   dcs_result_s      hold;
   logic [CNT_W-1:0] conv_cnt;
   logic             fifo_in_ready;

   // a start during a conversion is dropped, the held value is in use
   wire take_start = start_rise && (state == ST_SAMPLE);
   wire conv_done  = (state == ST_CONVERT) && (conv_cnt == CNT_ONE);
   wire store_ok   = (state == ST_STORE) && fifo_in_ready;
   wire [RESULT_W-1:0] pick_a = csel_s ? sample_a1_in : sample_a0_in;
   wire [RESULT_W-1:0] pick_b = csel_s ? sample_b1_in : sample_b0_in;

   always_comb begin
      next_state = state;
      case (state)
         ST_SAMPLE:  if (take_start) next_state = ST_HOLD;
         ST_HOLD:    next_state = ST_CONVERT;
         ST_CONVERT: if (conv_done) next_state = ST_STORE;
         ST_STORE:   if (store_ok) next_state = ST_SAMPLE;   // full buffer stalls here
         default:    next_state = ST_SAMPLE;
      endcase
   end

   // both halves latched in the same edge
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state    <= ST_SAMPLE;
         hold     <= RESULT_ZERO;
         conv_cnt <= CNT_ZERO;
         busy_out <= 1'b0;
      end else begin
         state    <= next_state;
         if (take_start) hold <= '{a: pick_a, b: pick_b};
         conv_cnt <= (state == ST_HOLD) ? CONV_CNT_LOAD :
                     (conv_cnt != CNT_ZERO) ? conv_cnt - CNT_ONE : CNT_ZERO;
         busy_out <= (next_state != ST_SAMPLE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // result buffer
   logic        fifo_valid;
   dcs_result_s fifo_data;
   logic        xfer_start;

   dcs_fifo #(
      .WIDTH (PAIR_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_in    (clk_sys_in),
      .nrst_in       (nrst_in),
      .in_valid_in   (state == ST_STORE),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (hold),
      .out_valid_out (fifo_valid),
      .out_ready_in  (xfer_start),
      .out_data_out  (fifo_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // serial transfer
   logic [PAIR_W-1:0]   shreg;
   logic [CNT_W-1:0]    bit_cnt;
   logic [RESULT_W-1:0] sin_shreg;

   // read only counts with chip select low and no transfer running
   assign xfer_start = rd_rise && !cs_n_s && (bit_cnt == CNT_ZERO);
   wire shifting     = (bit_cnt != CNT_ZERO);
   // one line carries both results back to back, so twice the length
   wire [CNT_W-1:0]  xfer_len = osel_s ? LEN_DUAL : LEN_SINGLE;
   wire [PAIR_W-1:0] load_val = fifo_valid ? fifo_data : RESULT_ZERO;
   wire              last_bit = (bit_cnt == CNT_ONE);

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         shreg   <= RESULT_ZERO;
         bit_cnt <= CNT_ZERO;
      end else if (xfer_start) begin
         shreg   <= load_val;
         bit_cnt <= xfer_len;
      end else if (shifting) begin
         shreg   <= {shreg[PAIR_W-2:0], 1'b0};
         bit_cnt <= bit_cnt - CNT_ONE;
      end
   end

   // lines change on rising edges only, so they sit still at the falling edge
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         serial_out_conv_a_out    <= 1'b0;
         serial_out_conv_b_out    <= 1'b0;
         serial_out_conv_a_oe_out <= 1'b0;
         serial_out_conv_b_oe_out <= 1'b0;
      end else begin
         serial_out_conv_a_out    <= shifting && shreg[PAIR_W-1];
         serial_out_conv_b_out    <= shifting && osel_s && shreg[RESULT_W-1];
         serial_out_conv_a_oe_out <= !cs_n_s;
         serial_out_conv_b_oe_out <= !cs_n_s && osel_s;
      end
   end

   // serial input shifts in step with the output bits
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sin_shreg           <= WORD_ZERO;
         serial_in_word_out  <= WORD_ZERO;
         serial_in_valid_out <= 1'b0;
      end else begin
         if (shifting) sin_shreg <= {sin_shreg[RESULT_W-2:0], sin_s};
         if (last_bit) serial_in_word_out <= {sin_shreg[RESULT_W-2:0], sin_s};
         serial_in_valid_out <= last_bit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_take;
      take_start;
   endsequence

   sequence s_convert_run;
      (state == ST_CONVERT) [*8];
   endsequence

   chk_hold_on_start: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      s_take |=> (state == ST_HOLD) && busy_out)
      else $error("start edge did not enter hold");
   chk_conv_next_edge: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (state == ST_HOLD) |=> s_convert_run)
      else $error("conversion did not start on next edge");
   chk_busy_spans: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      s_take |=> busy_out [*8] ##14 busy_out)
      else $error("busy dropped before conversion end");
   chk_busy_fall_edge: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      $fell(busy_out) |-> ($past(state) == ST_STORE) && (state == ST_SAMPLE))
      else $error("busy fell without completed conversion");
   chk_rd_ignored_cs: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (rd_rise && cs_n_s && !shifting) |=> !shifting)
      else $error("read accepted with chip select high");
   chk_oe_follows_cs: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      cs_n_s |=> !serial_out_conv_a_oe_out && !serial_out_conv_b_oe_out)
      else $error("lines driven with chip select high");
   chk_both_lines: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (osel_s && !cs_n_s) |=> serial_out_conv_a_oe_out && serial_out_conv_b_oe_out)
      else $error("both lines not driven in dual mode");
   chk_b_line_idle: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      !osel_s |=> !serial_out_conv_b_oe_out && !serial_out_conv_b_out)
      else $error("line b active in single mode");
   chk_msb_first: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (xfer_start && fifo_valid) |-> ##2 (serial_out_conv_a_out == $past(fifo_data.a[RESULT_W-1], 2)))
      else $error("first bit is not the msb");
   chk_channel_pick: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      s_take |=> (hold.a == $past(pick_a)) && (hold.b == $past(pick_b)))
      else $error("held value from wrong channel");
   chk_frame_length: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      xfer_start |=> (bit_cnt == $past(xfer_len)))
      else $error("transfer length not set by read");
endmodule

// file: testbench/dcs_host_model.sv
`timescale 1ns/1ps
module dcs_host_model
   import dcs_pkg::*;
(
   // clock
   input  wire logic clk_sys_in,
   // pins toward the converter
   output logic      conversion_start_out,
   output logic      rd_out,
   output logic      cs_n_out,
   output logic      serial_in_out,
   // pins from the converter
   input  wire logic busy_in,
   input  wire logic line_a_in,
   input  wire logic line_a_oe_in,
   input  wire logic line_b_in,
   input  wire logic line_b_oe_in
);
   logic xfer = 1'b0;
   logic si_val = 1'b0;
   logic idle_pat = 1'b0;
   // outside frames the input toggles, so stale data never looks valid
   assign serial_in_out = xfer ? si_val : idle_pat;
   initial begin
      conversion_start_out = 1'b0;
      rd_out = 1'b0;
      cs_n_out = 1'b1;
   end
   always @(negedge clk_sys_in) idle_pat <= ~idle_pat;
   ////////////////////////////////////////////////////////////////////////////
   // chip select, settled through the converter's input sync
   task automatic set_cs(input logic v);
      @(negedge clk_sys_in);
      cs_n_out = v;
      repeat (4) @(posedge clk_sys_in);
      #1;
   endtask
   // start held until busy answers; rise and busy length in clocks
   task automatic convert(output int rise, output int len);
      @(negedge clk_sys_in);
      conversion_start_out = 1'b1;
      for (rise = 1; rise < 9; rise++) begin
         @(posedge clk_sys_in);
         #1;
         if (busy_in) break;
      end
      @(negedge clk_sys_in);
      conversion_start_out = 1'b0;
      for (len = 1; len < 60; len++) begin
         @(posedge clk_sys_in);
         #1;
         if (!busy_in) break;
      end
   endtask
   // one framed transfer; an undriven line reads back unknown
   task automatic read(input logic si, input int nbits, output logic [23:0] a_word,
                       output logic [23:0] b_word, output logic b_seen);
      a_word = 24'h0;
      b_word = 24'h0;
      b_seen = 1'b0;
      @(negedge clk_sys_in);
      rd_out = 1'b1;
      si_val = si;
      xfer = 1'b1;
      repeat (4) @(posedge clk_sys_in);
      for (int i = 0; i < nbits; i++) begin
         @(negedge clk_sys_in);
         if (i == 1) rd_out = 1'b0;
         a_word = {a_word[22:0], line_a_oe_in ? line_a_in : 1'bx};
         b_word = {b_word[22:0], line_b_oe_in ? line_b_in : 1'bx};
         b_seen = b_seen | line_b_oe_in | line_b_in;
      end
      xfer = 1'b0;
   endtask
endmodule

// file: testbench/dcs_converter_port_tb.sv
`timescale 1ns/1ps
module dcs_converter_port_tb
   import dcs_pkg::*;
;
   logic                clk_sys_in, nrst_in, conv_start, rd, cs_n, si, chsel, osel;
   logic [RESULT_W-1:0] s_a0, s_a1, s_b0, s_b1, si_word;
   logic                busy, sa, sa_oe, sb, sb_oe, si_valid;
   logic [23:0]         aw, bw;
   logic                bs;
   int                  err_count = 0;
   int                  samples_checked = 0;
   int                  rise, len;

   dcs_converter_port u_dcs_converter_port (
      .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .conversion_start_in(conv_start),
      .rd_in(rd), .cs_n_in(cs_n), .serial_in_in(si), .channel_select_pin_in(chsel),
      .output_select_pin_in(osel), .sample_a0_in(s_a0), .sample_a1_in(s_a1),
      .sample_b0_in(s_b0), .sample_b1_in(s_b1), .busy_out(busy),
      .serial_out_conv_a_out(sa), .serial_out_conv_a_oe_out(sa_oe),
      .serial_out_conv_b_out(sb), .serial_out_conv_b_oe_out(sb_oe),
      .serial_in_word_out(si_word), .serial_in_valid_out(si_valid));
   dcs_host_model u_dcs_host_model (
      .clk_sys_in(clk_sys_in), .conversion_start_out(conv_start), .rd_out(rd),
      .cs_n_out(cs_n), .serial_in_out(si), .busy_in(busy), .line_a_in(sa),
      .line_a_oe_in(sa_oe), .line_b_in(sb), .line_b_oe_in(sb_oe));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checked %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // both channels, both lines, timing of busy
   task automatic t_dual();
      for (int ch = 0; ch < 2; ch++) begin
         @(negedge clk_sys_in);
         chsel = ch[0];
         osel = 1'b1;
         u_dcs_host_model.convert(rise, len);
         check(rise, SYNC_STAGES + 1);
         check(len, 32'h17);
         u_dcs_host_model.read(ch[0], 12, aw, bw, bs);
         check(aw[11:0], ch ? s_a1 : s_a0);
         check(bw[11:0], ch ? s_b1 : s_b0);
         check(si_valid, 1'b1);
         repeat (3) @(posedge clk_sys_in);
         check(si_word, {12{ch[0]}});
         check(si_valid, 1'b0);
      end
   endtask
   // single line carries a then b, line b stays quiet
   task automatic t_single();
      @(negedge clk_sys_in);
      osel = 1'b0;
      chsel = 1'b0;
      u_dcs_host_model.convert(rise, len);
      u_dcs_host_model.read(1'b0, 24, aw, bw, bs);
      check(aw, {s_a0, s_b0});
      check(bs, 1'b0);
   endtask
   // deselected: lines released and read ignored, so nothing is popped
   task automatic t_select();
      @(negedge clk_sys_in);
      osel = 1'b1;
      chsel = 1'b1;
      u_dcs_host_model.set_cs(1'b1);
      check({sa_oe, sb_oe}, 2'h0);
      u_dcs_host_model.convert(rise, len);
      u_dcs_host_model.read(1'b0, 12, aw, bw, bs);
      check(aw[11:0], 12'hXXX);
      u_dcs_host_model.set_cs(1'b0);
      check({sa_oe, sb_oe}, 2'h3);
      u_dcs_host_model.read(1'b0, 12, aw, bw, bs);
      check({aw[11:0], bw[11:0]}, {s_a1, s_b1});
   endtask
   // fill the buffer past full, then drain in order and once more when empty
   task automatic t_fill();
      @(negedge clk_sys_in);
      chsel = 1'b0;
      for (int i = 0; i < 33; i++) begin
         @(negedge clk_sys_in);
         s_a0 = 12'h100 + i[11:0];
         s_b0 = 12'h200 + i[11:0];
         u_dcs_host_model.convert(rise, len);
         check(len, (i < 32) ? 32'h17 : 32'h3C);
      end
      for (int i = 0; i < 34; i++) begin
         u_dcs_host_model.read(1'b1, 12, aw, bw, bs);
         check(aw[11:0], (i < 33) ? 12'h100 + i[11:0] : 12'h000);
         check(bw[11:0], (i < 33) ? 12'h200 + i[11:0] : 12'h000);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end
   // whole run needs some 1700 clocks
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      err_count++;
      conclude();
   end
   initial begin
      nrst_in = 1'b0;
      chsel = 1'b0;
      osel = 1'b1;
      s_a0 = 12'h5A1;
      s_a1 = 12'hC3E;
      s_b0 = 12'h0F7;
      s_b1 = 12'h9D2;
      repeat (16) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      nrst_in = 1'b1;
      u_dcs_host_model.set_cs(1'b0);
      t_dual();
      t_single();
      t_select();
      t_fill();
      conclude();
   end
endmodule
